// [logic/bwur_params.svh]
// Offsets, field positions and reset values of the window-upper register bank.
// Included by the package and the register bank file; definitions only.
`ifndef BWUR_PARAMS_SVH
`define BWUR_PARAMS_SVH
`define BWUR_OFS_PF_BASE_LO 8'h24
`define BWUR_OFS_PF_BASE_HI 8'h28
`define BWUR_OFS_PF_LIMIT_HI 8'h2c
`define BWUR_OFS_IO_HI 8'h30
`define BWUR_OFS_CAP_PTR 8'h34
`define BWUR_IO_BASE_LSB 0
`define BWUR_IO_LIMIT_LSB 16
`define BWUR_PF_ADDR64_CODE 4'h1
`define BWUR_PF_BASE_LO_LSB 4
`define BWUR_PF_LIMIT_LO_LSB 20
`define BWUR_PF_LOW_BITS 20
`define BWUR_CAP_PTR_VAL 8'hdc
`define BWUR_RST_32 32'h0000_0000
`define BWUR_RST_16 16'h0000
`define BWUR_RST_12 12'h000
`endif

// [logic/bwur_pkg.sv]
// Types shared by the window-upper register bank.
// Assumes the constants header is on the include path.
`include "bwur_params.svh"
package bwur_pkg;
  typedef logic [31:0] bwur_word_t;
  typedef logic [7:0] bwur_addr_t;
  typedef logic [1:0] bwur_resp_t;
  typedef logic [63:0] bwur_addr64_t;
  localparam bwur_resp_t BWUR_RESP_OKAY = 2'h0;
  localparam bwur_resp_t BWUR_RESP_SLVERR = 2'h2;
endpackage : bwur_pkg

// [logic/bwur_window_cmp.sv]
// Window comparator: base <= address <= limit.
// Assumes base and limit are already assembled to full width.
`timescale 1ns/1ps
`default_nettype none
module bwur_window_cmp #(
  parameter int W = 64
) (
  // Window and address
  input wire logic [W-1:0] base,
  input wire logic [W-1:0] limit,
  input wire logic [W-1:0] addr,
  // Result
  output logic hit
);
  assign hit = (addr >= base) && (addr <= limit); // [RULE8]
endmodule : bwur_window_cmp
`default_nettype wire

// [logic/bwur_regs.sv]
// Upper-half window registers of a bridge header, behind an AXI4-Lite slave.
// Assumes one clock, synchronous inputs, one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none
`include "bwur_params.svh"
// Contract
// [RULE1] Prefetch base high word, RW, resets zero
// [RULE2] Prefetch limit high word, RW, resets zero
// [RULE3] I/O base high half, RW, resets zero
// [RULE4] I/O limit high half, RW, resets zero
// [RULE5] Capability pointer reads DCh, writes ignored
// [RULE6] Prefetch base low 20 bits are zero
// [RULE7] Prefetch addressing-type field reads 0001
// [RULE8] Forward when base <= address <= limit
module bwur_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire bwur_pkg::bwur_addr_t s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire bwur_pkg::bwur_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output bwur_pkg::bwur_resp_t s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire bwur_pkg::bwur_addr_t s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output bwur_pkg::bwur_word_t s_axi_rdata,
  output bwur_pkg::bwur_resp_t s_axi_rresp,
  // Lower prefetch fields from the rest of the header
  input wire logic [11:0] pf_base_lo,
  input wire logic [11:0] pf_limit_lo,
  // Prefetch window check
  input wire bwur_pkg::bwur_addr64_t pf_addr,
  output logic pf_hit,
  // Assembled windows for the comparators
  output bwur_pkg::bwur_addr64_t pf_base_full,
  output bwur_pkg::bwur_addr64_t pf_limit_full,
  output logic [15:0] io_base_high,
  output logic [15:0] io_limit_high
);
  import bwur_pkg::*;

  bwur_word_t pf_base_hi_ff;
  bwur_word_t pf_limit_hi_ff;
  logic [15:0] io_base_hi_ff;
  logic [15:0] io_limit_hi_ff;
  logic aw_held_ff;
  logic w_held_ff;
  bwur_addr_t awaddr_ff;
  bwur_word_t wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  bwur_resp_t bresp_ff;
  logic rvalid_ff;
  bwur_word_t rdata_ff;
  bwur_resp_t rresp_ff;
  logic wr_fire;
  bwur_addr_t wr_addr;
  bwur_word_t wr_data;
  logic [3:0] wr_strb;
  logic wr_known;
  bwur_word_t nxt_rdata;
  logic nxt_rhit;

  // Address and data may arrive in either order; each is held once taken
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_fire = (aw_held_ff || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_ff || (s_axi_wvalid && s_axi_wready)) && !bvalid_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= `BWUR_RST_32;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Offset 24h and 34h are read-only here, so they answer OKAY and drop data
  always_comb
  begin
    unique case ({wr_addr[7:2], 2'b00})
      `BWUR_OFS_PF_BASE_LO, `BWUR_OFS_PF_BASE_HI, `BWUR_OFS_PF_LIMIT_HI,
      `BWUR_OFS_IO_HI, `BWUR_OFS_CAP_PTR: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // Per-byte writes to the four writable fields
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_byte
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pf_base_hi_ff[8*gb +: 8] <= 8'h00; // [RULE1]
          pf_limit_hi_ff[8*gb +: 8] <= 8'h00; // [RULE2]
        end
        else if (wr_fire && wr_strb[gb])
        begin
          if ({wr_addr[7:2], 2'b00} == `BWUR_OFS_PF_BASE_HI)
          begin
            pf_base_hi_ff[8*gb +: 8] <= wr_data[8*gb +: 8]; // [RULE1]
          end
          if ({wr_addr[7:2], 2'b00} == `BWUR_OFS_PF_LIMIT_HI)
          begin
            pf_limit_hi_ff[8*gb +: 8] <= wr_data[8*gb +: 8]; // [RULE2]
          end
        end
      end
    end
    for (gb = 0; gb < 2; gb++)
    begin : g_io
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          io_base_hi_ff[8*gb +: 8] <= 8'h00; // [RULE3]
          io_limit_hi_ff[8*gb +: 8] <= 8'h00; // [RULE4]
        end
        else if (wr_fire && ({wr_addr[7:2], 2'b00} == `BWUR_OFS_IO_HI))
        begin
          if (wr_strb[gb])
          begin
            io_base_hi_ff[8*gb +: 8] <= wr_data[8*gb +: 8]; // [RULE3]
          end
          if (wr_strb[gb + 2])
          begin
            io_limit_hi_ff[8*gb +: 8] <= wr_data[`BWUR_IO_LIMIT_LSB + 8*gb +: 8]; // [RULE4]
          end
        end
      end
    end
  endgenerate

  // Write response
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= BWUR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_known ? BWUR_RESP_OKAY : BWUR_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read decode
  always_comb
  begin
    nxt_rdata = `BWUR_RST_32;
    nxt_rhit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `BWUR_OFS_PF_BASE_LO:
      begin
        nxt_rdata[3:0] = `BWUR_PF_ADDR64_CODE; // [RULE7]
        nxt_rdata[15:4] = pf_base_lo;
        nxt_rdata[19:16] = `BWUR_PF_ADDR64_CODE; // [RULE7]
        nxt_rdata[31:20] = pf_limit_lo;
      end
      `BWUR_OFS_PF_BASE_HI: nxt_rdata = pf_base_hi_ff; // [RULE1]
      `BWUR_OFS_PF_LIMIT_HI: nxt_rdata = pf_limit_hi_ff; // [RULE2]
      `BWUR_OFS_IO_HI: nxt_rdata = {io_limit_hi_ff, io_base_hi_ff}; // [RULE3] [RULE4]
      `BWUR_OFS_CAP_PTR: nxt_rdata[7:0] = `BWUR_CAP_PTR_VAL; // [RULE5]
      default: nxt_rhit = 1'b0;
    endcase
  end

  // Read channel; data come from a register
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `BWUR_RST_32;
      rresp_ff <= BWUR_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rhit ? BWUR_RESP_OKAY : BWUR_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Assembled windows; low bits fixed, so base is 1 MB aligned
  assign pf_base_full = {pf_base_hi_ff, pf_base_lo, `BWUR_PF_LOW_BITS'(0)}; // [RULE6]
  assign pf_limit_full = {pf_limit_hi_ff, pf_limit_lo, {`BWUR_PF_LOW_BITS{1'b1}}};
  assign io_base_high = io_base_hi_ff;
  assign io_limit_high = io_limit_hi_ff;

  bwur_window_cmp #(
    .W(64)
  ) u_pf_cmp (
    .base(pf_base_full),
    .limit(pf_limit_full),
    .addr(pf_addr),
    .hit(pf_hit)
  );
endmodule : bwur_regs
`default_nettype wire

// [verification/bwur_regs_chk.sv]
// Checker for the window-upper register bank, bound onto its ports.
// Assumes one clock domain and the shared package compiled first.
`timescale 1ns/1ps
`default_nettype none
module bwur_regs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire bwur_pkg::bwur_addr_t s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bwur_pkg::bwur_word_t s_axi_rdata,
  // Window
  input wire logic [11:0] pf_base_lo,
  input wire logic [11:0] pf_limit_lo,
  input wire bwur_pkg::bwur_addr64_t pf_addr,
  input wire logic pf_hit,
  input wire bwur_pkg::bwur_addr64_t pf_base_full,
  input wire bwur_pkg::bwur_addr64_t pf_limit_full,
  // I/O window halves
  input wire logic [15:0] io_base_high,
  input wire logic [15:0] io_limit_high
);
  import bwur_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  cap_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h34
    |=> s_axi_rdata == 32'hdc) else $error("pointer wrong");
  base_low_a: assert property (pf_base_full[31:0] == {pf_base_lo, 20'h0})
    else $error("base low bits wrong");
  limit_low_a: assert property (pf_limit_full[31:0] == {pf_limit_lo, 20'hfffff})
    else $error("limit low bits wrong");
  hit_a: assert property (pf_hit == (pf_addr >= pf_base_full && pf_addr <= pf_limit_full))
    else $error("window decision wrong");
  // Mid-run reset follows writes, so this one can really trip
  reset_clear_a: assert property ($rose(rst_n) |-> pf_base_full[63:32] == 32'h0
    && pf_limit_full[63:32] == 32'h0 && io_base_high == 16'h0 && io_limit_high == 16'h0)
    else $error("window not cleared by reset");
  addr_type_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h24
    |=> s_axi_rdata[3:0] == 4'h1 && s_axi_rdata[19:16] == 4'h1)
    else $error("addressing type wrong");
endmodule : bwur_regs_chk
`default_nettype wire

// [verification/bwur_hdr_model.sv]
// Rest of the header: holds the lower prefetch base and limit fields.
// Assumes the bench loads both fields with one strobe.
`timescale 1ns/1ps
`default_nettype none
module bwur_hdr_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load
  input wire logic ld,
  input wire logic [23:0] ld_val,
  // Lower fields
  output logic [11:0] pf_base_lo,
  output logic [11:0] pf_limit_lo
);
  logic [23:0] lo_ff;
  assign {pf_limit_lo, pf_base_lo} = lo_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lo_ff <= 24'h0;
    else if (ld)
      lo_ff <= ld_val;
  end
endmodule : bwur_hdr_model
`default_nettype wire

// [verification/bwur_regs_tb_top.sv]
// Bench for the window-upper register bank over the register bus.
// Assumes package, header model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bwur_regs_tb_top;
  import bwur_pkg::*;
  typedef struct {bwur_addr_t a; bwur_word_t w; bwur_word_t r; bwur_resp_t s;} bwur_row_t;
  logic clk, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, ld, hit;
  logic [3:0] ws;
  logic [23:0] ldv;
  logic [11:0] blo, llo;
  logic [15:0] iob, iol;
  bwur_addr_t awa, ara;
  bwur_word_t wd, rd, got;
  bwur_resp_t bs, rs, gs;
  bwur_addr64_t pa, bf, lf;
  int err_count, comparisons;
  bwur_row_t rows[6] = '{'{8'h28, 32'hffffffff, 32'hffffffff, 2'h0},
    '{8'h2c, 32'h12345678, 32'h12345678, 2'h0}, '{8'h30, 32'habcd1234, 32'habcd1234, 2'h0},
    '{8'h34, 32'hffffffff, 32'hdc, 2'h0}, '{8'h24, 32'hffffffff, 32'h45611231, 2'h0},
    '{8'h3c, 32'h1, 32'h0, 2'h2}};
  bwur_addr64_t pas[4] = '{64'h1_1230_0000, 64'h1_122f_ffff, 64'h1_456f_ffff, 64'h1_4570_0000};
  always #2 clk = ~clk;
  bwur_hdr_model hdr_u (.clk, .rst_n, .ld, .ld_val(ldv), .pf_base_lo(blo), .pf_limit_lo(llo));
  bwur_regs dut_u (.clk, .rst_n, .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bs), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
    .s_axi_rresp(rs), .pf_base_lo(blo), .pf_limit_lo(llo), .pf_addr(pa), .pf_hit(hit),
    .pf_base_full(bf), .pf_limit_full(lf), .io_base_high(iob), .io_limit_high(iol));
  task automatic chk(input bwur_word_t g, input bwur_word_t e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Answer taken one cycle late on purpose, so the hold checks see a wait
  task automatic wr(input bwur_addr_t a, input bwur_word_t d, input logic [3:0] s);
    logic ad, dd;
    ad = 0;
    dd = 0;
    {awv, wv} <= 2'h3;
    {awa, wd, ws} <= {a, d, s};
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (awr) ad = 1;
      if (wrd) dd = 1;
      if (ad) awv <= 0;
      if (dd) wv <= 0;
    end
    @(posedge clk);
    br <= 1;
    do @(posedge clk); while (!bv);
    gs = bs;
    br <= 0;
  endtask : wr
  task automatic rd_word(input bwur_addr_t a);
    arv <= 1;
    ara <= a;
    do @(posedge clk); while (!arr);
    arv <= 0;
    @(posedge clk);
    rr <= 1;
    do @(posedge clk); while (!rv);
    got = rd;
    gs = rs;
    rr <= 0;
  endtask : rd_word
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial
  begin
    clk = 0;
    rst_n = 0;
    {awv, wv, br, arv, rr, ld} = '0;
    {awa, ara, wd, ws, ldv, pa} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      rd_word(8'h28 + 8'(4 * i));
      chk(got, 32'h0);
    end
    ld <= 1;
    ldv <= 24'h456123;
    @(posedge clk);
    ld <= 0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w, 4'hf);
      chk(32'(gs), 32'(rows[i].s));
      rd_word(rows[i].a);
      chk(got, rows[i].r);
      chk(32'(gs), 32'(rows[i].s));
    end
    chk({iol, iob}, 32'habcd1234);
    wr(8'h28, 32'h0, 4'h2);
    rd_word(8'h28);
    chk(got, 32'hffff00ff);
    wr(8'h28, 32'h1, 4'hf);
    wr(8'h2c, 32'h1, 4'hf);
    chk(bf[63:32], 32'h1);
    chk(bf[31:0], 32'h1230_0000);
    chk(lf[63:32], 32'h1);
    foreach (pas[i])
    begin
      pa <= pas[i];
      @(posedge clk);
      chk(32'(hit), 32'(i % 2 == 0));
    end
    // Second reset in mid-run must clear what software wrote
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd_word(8'h2c);
    chk(got, 32'h0);
    chk({iol, iob}, 32'h0);
    chk(bf[63:32], 32'h0);
    complete_run();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : bwur_regs_tb_top
bind bwur_regs bwur_regs_chk chk_u (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pf_base_lo, .pf_limit_lo,
  .pf_addr, .pf_hit, .pf_base_full, .pf_limit_full, .io_base_high, .io_limit_high);
`default_nettype wire
